// >>> hw/free_running_timer.sv
// free-running 16-bit timer with byte views, overflow flag and two capture channels
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module free_running_timer
	import frt_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        halt_mode,
	input  wire logic        cpu_irq_mask,
	input  wire logic        ext_clock_pin,
	input  wire logic        capture_pin_one,
	input  wire logic        capture_pin_two,
	output logic             timer_irq,
	output logic      [15:0] count_value
);
	logic [15:0] count_r;
	logic [7:0]  ctrl_one_r;
	logic [7:0]  ctrl_two_r;
	logic [7:0]  low_buf_r;
	logic        low_buf_valid_r;
	logic        ovf_flag_r;
	logic        ovf_armed_r;
	logic [2:0]  presc_r;
	logic [2:0]  ext_sync_r;
	logic [1:0]  cap_flag_r;
	logic [1:0]  cap_armed_r;
	logic [1:0]  cap_block_r;
	logic [15:0] cap_val_r [2];
	logic [2:0]  cap_sync_r [2];
	logic [7:0]  prdata_nxt;
	logic        tick;
	logic        ext_edge;
	logic        wr_en;
	logic        rd_en;
	logic        acc_en;
	logic        cnt_low_rd;
	logic        alt_low_rd;
	logic        status_rd;
	logic        reload;
	logic        wrap;
	logic [1:0]  clk_sel;
	logic        pulse_mode;
	logic [1:0]  cap_pins;
	logic [1:0]  cap_edge_sel;
	logic [1:0]  cap_event;
	logic [1:0]  cap_high_rd;
	logic [1:0]  cap_low_acc;
	apb_req_t    req;

	assign req = '{addr: paddr, write: pwrite, wdata: pwdata[7:0]};
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign acc_en  = psel && penable;
	assign wr_en   = acc_en && req.write;
	assign rd_en   = acc_en && !req.write;
	assign cnt_low_rd = rd_en && (req.addr == ADDR_CNT_LOW);
	assign alt_low_rd = rd_en && (req.addr == ADDR_ALT_LOW);
	assign status_rd  = rd_en && (req.addr == ADDR_STATUS);
	assign reload = wr_en && ((req.addr == ADDR_CNT_LOW) || (req.addr == ADDR_ALT_LOW));
	assign clk_sel = {ctrl_two_r[C2_CLK_HI], ctrl_two_r[C2_CLK_LO]};
	assign pulse_mode = ctrl_two_r[C2_ONE_PULSE] || ctrl_two_r[C2_PWM];
	assign count_value = count_r;

	// external clock: two-stage synchroniser, edge taken from stages two and three
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ext_sync_r <= 3'h0;
		else
			ext_sync_r <= {ext_sync_r[1:0], ext_clock_pin};
	end
	// relies on pin edges spaced four cpu clocks apart
	assign ext_edge = ctrl_two_r[C2_EXT_EDGE] ? (ext_sync_r[1] && !ext_sync_r[2])
		: (!ext_sync_r[1] && ext_sync_r[2]);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			presc_r <= 3'h0;
		else if (!halt_mode)
			presc_r <= presc_r + 3'h1;
	end

	always_comb
	begin
		tick = 1'b0;
		case (clk_sel)
			CLK_DIV2: tick = (presc_r[0] == 1'b1);
			CLK_DIV4: tick = (presc_r[1:0] == 2'h3);
			CLK_DIV8: tick = (presc_r == 3'h7);
			CLK_EXT:  tick = ext_edge;
			default:  tick = 1'b0;
		endcase
		if (halt_mode)
			tick = 1'b0;
	end
	assign wrap = tick && !reload && (count_r == COUNT_TOP);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_r <= COUNT_RELOAD;
		else if (reload)
			count_r <= COUNT_RELOAD;
		else if (tick)
			count_r <= count_r + 16'h0001;
	end

	// a high byte read with no buffered low byte pending freezes the low byte at its setup edge,
	// the edge that loads prdata, so both bytes come from one count
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			low_buf_r       <= 8'h00;
			low_buf_valid_r <= 1'b0;
		end
		else if (cnt_low_rd || alt_low_rd)
			low_buf_valid_r <= 1'b0;
		else if (psel && !penable && !req.write && !low_buf_valid_r
			&& ((req.addr == ADDR_CNT_HIGH) || (req.addr == ADDR_ALT_HIGH)))
		begin
			low_buf_r       <= count_r[7:0];
			low_buf_valid_r <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_one_r <= 8'h00;
			ctrl_two_r <= 8'h00;
		end
		else if (wr_en && (req.addr == ADDR_CTRL_ONE))
			ctrl_one_r <= req.wdata;
		else if (wr_en && (req.addr == ADDR_CTRL_TWO))
			ctrl_two_r <= req.wdata;
	end

	// overflow flag: set wins over the clear step
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ovf_flag_r  <= 1'b0;
			ovf_armed_r <= 1'b0;
		end
		else
		begin
			if (wrap)
				ovf_flag_r <= 1'b1;
			else if (ovf_armed_r && acc_en && (req.addr == ADDR_CNT_LOW))
				ovf_flag_r <= 1'b0;
			if (status_rd && ovf_flag_r)
				ovf_armed_r <= 1'b1;
			else if ((acc_en && (req.addr == ADDR_CNT_LOW)) || !ovf_flag_r)
				ovf_armed_r <= 1'b0;
		end
	end

	assign cap_pins       = {capture_pin_two, capture_pin_one};
	assign cap_edge_sel   = {ctrl_two_r[C2_EDGE2], ctrl_one_r[C1_EDGE1]};

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_cap
			logic [11:0] high_addr;
			logic [11:0] low_addr;
			assign high_addr = (ch == 0) ? ADDR_CAP1_HIGH : ADDR_CAP2_HIGH;
			assign low_addr  = (ch == 0) ? ADDR_CAP1_LOW : ADDR_CAP2_LOW;
			// high read blocks at its setup edge, where prdata takes the value,
			// so a capture in the same cycle cannot split the two bytes
			assign cap_high_rd[ch] = psel && !penable && !req.write && (req.addr == high_addr);
			assign cap_low_acc[ch] = acc_en && (req.addr == low_addr);

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					cap_sync_r[ch] <= 3'h0;
				else
					cap_sync_r[ch] <= {cap_sync_r[ch][1:0], cap_pins[ch]};
			end
			assign cap_event[ch] = (cap_edge_sel[ch] ?
				(cap_sync_r[ch][1] && !cap_sync_r[ch][2]) :
				(!cap_sync_r[ch][1] && cap_sync_r[ch][2]))
				&& !cap_block_r[ch] && !cap_high_rd[ch]
				&& !((ch == 0) && pulse_mode);

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					cap_val_r[ch] <= 16'h0000;
				else if (cap_event[ch])
					cap_val_r[ch] <= count_r;
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					cap_block_r[ch] <= 1'b0;
				else if (rd_en && (req.addr == low_addr))
					cap_block_r[ch] <= 1'b0;
				else if (cap_high_rd[ch])
					cap_block_r[ch] <= 1'b1;
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cap_flag_r[ch]  <= 1'b0;
					cap_armed_r[ch] <= 1'b0;
				end
				else
				begin
					if (cap_event[ch])
						cap_flag_r[ch] <= 1'b1;
					else if (cap_armed_r[ch] && cap_low_acc[ch])
						cap_flag_r[ch] <= 1'b0;
					if (status_rd && cap_flag_r[ch])
						cap_armed_r[ch] <= 1'b1;
					else if (cap_low_acc[ch] || !cap_flag_r[ch])
						cap_armed_r[ch] <= 1'b0;
				end
			end
		end
	endgenerate

	// request stays asserted only while enable and cpu mask both allow it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_irq <= 1'b0;
		else
			timer_irq <= !cpu_irq_mask && ((ovf_flag_r && ctrl_one_r[C1_OVF_IE])
				|| ((|cap_flag_r) && ctrl_one_r[C1_CAP_IE]));
	end

	always_comb
	begin
		prdata_nxt = 8'h00;
		if (req.addr == ADDR_CTRL_ONE)
			prdata_nxt = ctrl_one_r;
		else if (req.addr == ADDR_CTRL_TWO)
			prdata_nxt = ctrl_two_r;
		else if (req.addr == ADDR_STATUS)
		begin
			prdata_nxt[ST_CAP1] = cap_flag_r[0];
			prdata_nxt[ST_OVF]  = ovf_flag_r;
			prdata_nxt[ST_CAP2] = cap_flag_r[1];
		end
		else if (req.addr == ADDR_CAP1_HIGH)
			prdata_nxt = cap_val_r[0][15:8];
		else if (req.addr == ADDR_CAP1_LOW)
			prdata_nxt = cap_val_r[0][7:0];
		else if (req.addr == ADDR_CAP2_HIGH)
			prdata_nxt = cap_val_r[1][15:8];
		else if (req.addr == ADDR_CAP2_LOW)
			prdata_nxt = cap_val_r[1][7:0];
		else if ((req.addr == ADDR_CNT_HIGH) || (req.addr == ADDR_ALT_HIGH))
			prdata_nxt = count_r[15:8];
		else if ((req.addr == ADDR_CNT_LOW) || (req.addr == ADDR_ALT_LOW))
			prdata_nxt = low_buf_valid_r ? low_buf_r : count_r[7:0];
	end

	// read data registered in the setup phase, stable through the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= {24'h000000, prdata_nxt};
	end

	ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		wrap |=> ovf_flag_r)
		else $error("overflow flag not set after wrap");
	reload_a: assert property (@(posedge pclk) disable iff (!presetn)
		reload |=> (count_r == COUNT_RELOAD))
		else $error("counter not reloaded on low write");
	halt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(halt_mode && !reload) |=> $stable(count_r))
		else $error("counter moved during halt");
	div2_a: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && clk_sel == CLK_DIV2 && !halt_mode && !reload)
		##1 (clk_sel == CLK_DIV2 && !halt_mode && !reload)
		|=> (count_r != $past(count_r, 2)))
		else $error("divide by two rate wrong");
	alt_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf_flag_r && alt_low_rd && !cnt_low_rd) |=> ovf_flag_r)
		else $error("alternate low read cleared overflow");
	buf_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		(low_buf_valid_r && !cnt_low_rd && !alt_low_rd) |=> $stable(low_buf_r))
		else $error("buffered low byte changed");
	cap_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		cap_block_r[1] |=> $stable(cap_val_r[1]))
		else $error("capture while blocked");
	cap_one_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		pulse_mode |-> !cap_event[0])
		else $error("channel one captured in pulse mode");
	irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf_flag_r && ctrl_one_r[C1_OVF_IE] && !cpu_irq_mask) |=> timer_irq)
		else $error("overflow request missing");
	cap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		cap_event[1] |=> (cap_flag_r[1] && cap_val_r[1] == $past(count_r)))
		else $error("capture two not taken");
endmodule
`default_nettype wire

// >>> hw/frt_pkg.sv
// package: register map, field positions and constants of the free-running timer
package frt_pkg;
	localparam logic [11:0] ADDR_CTRL_ONE   = 12'h000;
	localparam logic [11:0] ADDR_CTRL_TWO   = 12'h004;
	localparam logic [11:0] ADDR_STATUS     = 12'h008;
	localparam logic [11:0] ADDR_CAP1_HIGH  = 12'h00c;
	localparam logic [11:0] ADDR_CAP1_LOW   = 12'h010;
	localparam logic [11:0] ADDR_CNT_HIGH   = 12'h014;
	localparam logic [11:0] ADDR_CNT_LOW    = 12'h018;
	localparam logic [11:0] ADDR_ALT_HIGH   = 12'h01c;
	localparam logic [11:0] ADDR_ALT_LOW    = 12'h020;
	localparam logic [11:0] ADDR_CAP2_HIGH  = 12'h024;
	localparam logic [11:0] ADDR_CAP2_LOW   = 12'h028;
	localparam logic [15:0] COUNT_RELOAD    = 16'hfffc;
	localparam logic [15:0] COUNT_TOP       = 16'hffff;
	// control one fields
	localparam int          C1_CAP_IE       = 7;
	localparam int          C1_OVF_IE       = 5;
	localparam int          C1_EDGE1        = 1;
	// control two fields
	localparam int          C2_ONE_PULSE    = 7;
	localparam int          C2_PWM          = 4;
	localparam int          C2_CLK_HI       = 3;
	localparam int          C2_CLK_LO       = 2;
	localparam int          C2_EDGE2        = 1;
	localparam int          C2_EXT_EDGE     = 0;
	// status fields
	localparam int          ST_CAP1         = 7;
	localparam int          ST_OVF          = 5;
	localparam int          ST_CAP2         = 4;
	localparam logic [1:0]  CLK_DIV2        = 2'h0;
	localparam logic [1:0]  CLK_DIV4        = 2'h1;
	localparam logic [1:0]  CLK_DIV8        = 2'h2;
	localparam logic [1:0]  CLK_EXT         = 2'h3;
	typedef struct packed
	{
		logic [11:0] addr;
		logic        write;
		logic [7:0]  wdata;
	} apb_req_t;
endpackage

// >>> dv/pin_source.sv
// external event sources for the timer's clock and capture pins
`timescale 1ns/1ps
`default_nettype none
module pin_source
(
	input  wire logic pclk,
	output logic      ext_clock_pin,
	output logic      capture_pin_one,
	output logic      capture_pin_two
);
	initial
	begin
		ext_clock_pin = 1'b0;
		capture_pin_one = 1'b0;
		capture_pin_two = 1'b0;
	end

	// each level is held eight clocks, so active edges stay well apart
	task automatic ext_level(input logic lvl);
		@(posedge pclk);
		ext_clock_pin <= lvl;
		repeat (8) @(posedge pclk);
	endtask

	task automatic cap_set(input int ch, input logic lvl);
		@(posedge pclk);
		if (ch == 1)
			capture_pin_one <= lvl;
		else
			capture_pin_two <= lvl;
		repeat (8) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for the free-running timer
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import frt_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        halt_mode, cpu_irq_mask, timer_irq;
	logic        ext_clock_pin, capture_pin_one, capture_pin_two;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] count_value;
	int          err_total, compares;

	free_running_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode),
		.cpu_irq_mask(cpu_irq_mask), .ext_clock_pin(ext_clock_pin),
		.capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two),
		.timer_irq(timer_irq), .count_value(count_value));
	pin_source u_src (.pclk(pclk), .ext_clock_pin(ext_clock_pin),
		.capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two));

	task automatic tally_and_finish();
		if (err_total == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// count expected after n timer ticks from a known start
	function automatic logic [15:0] after_ticks(input logic [15:0] c, input int n);
		return c + 16'(n);
	endfunction

	task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
		output logic [15:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata[15:0];
		chk("pslverr", 16'h0, {15'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [15:0] q;
		apb(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [11:0] a, input logic [15:0] exp, input string nm);
		logic [15:0] q;
		apb(a, 1'b0, 8'h00, q);
		chk(nm, exp, q);
	endtask

	task automatic st(input int b, input logic e, input string nm);
		logic [15:0] q;
		apb(ADDR_STATUS, 1'b0, 8'h00, q);
		chk(nm, {15'h0, e}, {15'h0, q[b]});
	endtask

	task automatic irq(input logic e, input string nm);
		repeat (3) @(negedge pclk);
		chk(nm, {15'h0, e}, {15'h0, timer_irq});
		@(posedge pclk);
	endtask

	// halt freezes the count so captured and buffered values are known
	task automatic hold(input logic h);
		@(posedge pclk);
		halt_mode <= h;
		repeat (3) @(posedge pclk);
	endtask

	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		err_total++;
		tally_and_finish();
	end

	initial
	begin
		logic [15:0] c;
		logic [15:0] q;
		logic [11:0] hi;
		logic [11:0] lo;
		logic        a;
		int          d;
		int          b;
		{presetn, psel, penable, pwrite, halt_mode, cpu_irq_mask} = 6'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		err_total = 0;
		compares = 0;
		d = $urandom(32'hcd23);
		repeat (16) @(posedge pclk);
		chk("reset count", COUNT_RELOAD, count_value);
		presetn <= 1'b1;
		wr(ADDR_CTRL_ONE, 8'h20);
		repeat (20) @(posedge pclk);
		st(ST_OVF, 1'b1, "overflow flag");
		irq(1'b1, "overflow irq");
		cpu_irq_mask <= 1'b1;
		irq(1'b0, "masked irq");
		cpu_irq_mask <= 1'b0;
		irq(1'b1, "pending irq");
		apb(ADDR_ALT_LOW, 1'b0, 8'h00, q);
		st(ST_OVF, 1'b1, "flag after alt low");
		apb(ADDR_CNT_LOW, 1'b0, 8'h00, q);
		st(ST_OVF, 1'b0, "flag after low");
		irq(1'b0, "irq after clear");
		for (int v = 0; v < 2; v++)
		begin
			hi = v ? ADDR_ALT_HIGH : ADDR_CNT_HIGH;
			lo = v ? ADDR_ALT_LOW : ADDR_CNT_LOW;
			hold(1'b1);
			c = count_value;
			rd(hi, {8'h0, c[15:8]}, "high byte");
			hold(1'b0);
			repeat ($urandom_range(40, 8)) @(posedge pclk);
			apb(hi, 1'b0, 8'h00, q);
			hold(1'b1);
			rd(lo, {8'h0, c[7:0]}, "buffered low");
			rd(lo, {8'h0, count_value[7:0]}, "live low");
			wr(lo, 8'($urandom));
			@(negedge pclk);
			chk("reload", COUNT_RELOAD, count_value);
		end
		rd(12'h0fc, 16'h0, "unmapped");
		hold(1'b0);
		for (int i = 0; i < 3; i++)
		begin
			wr(ADDR_CTRL_TWO, 8'(i << 2));
			d = 2 << i;
			@(negedge pclk);
			c = count_value;
			while (count_value === c) @(negedge pclk);
			c = count_value;
			repeat (16 * d) @(negedge pclk);
			chk("prescaled count", after_ticks(c, 16), count_value);
		end
		for (int e = 0; e < 2; e++)
		begin
			wr(ADDR_CTRL_TWO, 8'h0c | 8'(e));
			@(negedge pclk);
			c = count_value;
			u_src.ext_level(1'b1);
			@(negedge pclk);
			chk("ext rise", after_ticks(c, e), count_value);
			u_src.ext_level(1'b0);
			@(negedge pclk);
			chk("ext fall", after_ticks(c, 1), count_value);
		end
		wr(ADDR_CTRL_TWO, 8'h00);
		wr(ADDR_CTRL_ONE, 8'h82);
		for (int ch = 1; ch < 3; ch++)
		begin
			b = ch == 1 ? ST_CAP1 : ST_CAP2;
			a = ch == 1;
			hi = ch == 1 ? ADDR_CAP1_HIGH : ADDR_CAP2_HIGH;
			lo = hi + 12'h004;
			hold(1'b0);
			repeat ($urandom_range(30, 1)) @(posedge pclk);
			hold(1'b1);
			c = count_value;
			u_src.cap_set(ch, !a);
			st(b, 1'b0, "idle edge flag");
			u_src.cap_set(ch, a);
			irq(1'b1, "capture irq");
			st(b, 1'b1, "capture flag");
			rd(hi, {8'h0, c[15:8]}, "capture high");
			hold(1'b0);
			repeat (9) @(posedge pclk);
			hold(1'b1);
			u_src.cap_set(ch, !a);
			u_src.cap_set(ch, a);
			rd(lo, {8'h0, c[7:0]}, "blocked low");
			st(b, 1'b0, "flag cleared");
			irq(1'b0, "irq cleared");
			c = count_value;
			u_src.cap_set(ch, !a);
			u_src.cap_set(ch, a);
			st(b, 1'b1, "recapture flag");
			rd(hi, {8'h0, c[15:8]}, "recapture high");
			rd(lo, {8'h0, c[7:0]}, "recapture low");
		end
		for (int m = 0; m < 2; m++)
		begin
			wr(ADDR_CTRL_TWO, m ? 8'h10 : 8'h80);
			u_src.cap_set(1, 1'b0);
			u_src.cap_set(1, 1'b1);
			st(ST_CAP1, 1'b0, "channel one in pulse modes");
			u_src.cap_set(2, 1'b1);
			u_src.cap_set(2, 1'b0);
			st(ST_CAP2, 1'b1, "channel two in pulse modes");
			rd(ADDR_CAP2_LOW, {8'h0, count_value[7:0]}, "capture two in pulse modes");
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
